// [eeprom_model.sv]
// Behavioural EEPROM standing on the handler's memory port
`timescale 1ns/100ps
module eeprom_model (
   input  wire logic       clk,
   input  wire logic       req,
   input  wire logic       wr,
   input  wire logic [8:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       corrupt,
   output logic            ack,
   output logic [7:0]      rdata
);
   logic [7:0] mem [512];
   logic [1:0] cnt = 2'h0;
   // Answers after a stall; read data toggles so stale bytes never match
   always @(posedge clk) begin
      ack <= req && !ack && cnt == 2'h2;
      cnt <= (req && !ack && cnt != 2'h2) ? cnt + 2'h1 : 2'h0;
      rdata <= ~rdata;
      if (req && !ack && cnt == 2'h2) begin
         if (wr) mem[addr] <= wdata;
         rdata <= mem[addr] ^ {7'h00, corrupt & !wr}; // Read-back fault
      end
   end
endmodule

// [page_addr.sv]
// Memory address counter that wraps inside one page
`timescale 1ns/100ps
module page_addr (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic                      load,
   input  wire logic                      inc,
   input  wire logic                      big,
   input  wire logic [wr_pkg::ADDR_W-1:0] load_val,
   output logic [wr_pkg::ADDR_W-1:0]      addr_q
);
   localparam int unsigned AW = wr_pkg::ADDR_W;
   localparam int unsigned OB = wr_pkg::OFS_BIG;
   localparam int unsigned OS = wr_pkg::OFS_SMALL;
   logic [AW-1:0] addr_d;

   // Only the offset bits count; page bits change only on a load
   always_comb begin
      addr_d = addr_q;
      if (load) begin
         addr_d = load_val;
      end else if (inc && big) begin
         addr_d = {addr_q[AW-1:OB], addr_q[OB-1:0] + 1'b1};
      end else if (inc) begin
         addr_d = {addr_q[AW-1:OS], addr_q[OS-1:0] + 1'b1};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_q <= '0;
      end else begin
         addr_q <= addr_d;
      end
   end
endmodule

// [page_buf.sv]
// Staging memory for the data bytes of one write command
`timescale 1ns/100ps
module page_buf (
   input  wire logic                      clk,
   input  wire logic                      we,
   input  wire logic [wr_pkg::BUF_AW-1:0] waddr,
   input  wire logic [7:0]                wdata,
   input  wire logic [wr_pkg::BUF_AW-1:0] raddr,
   output logic [7:0]                     rdata
);
   logic [7:0] mem_q [wr_pkg::BUF_DEPTH];

   // Registered read; no reset, contents are always written first
   always_ff @(posedge clk) begin
      if (we) begin
         mem_q[waddr] <= wdata;
      end
      rdata <= mem_q[raddr];
   end
endmodule

// [user_zone_write_handler.sv]
// User zone write command interpreter: parse, check, write, verify, answer
//
// How it works
// - Large-memory write carries high then low address byte.
// - Only the low address bits step after each stored byte.
// - Writes past page end wrap to the same page start.
// - Only an active card answers; otherwise it stays silent.
// - Large-memory data bytes are encrypted only in encryption mode.
// - Large-memory parameter byte: bits 7..1 zero, bit 0 address bit eight.
// - Length is count minus one, within page; eight bytes with anti-tearing.
// - Write-lock or program-only allows one byte per large-memory write.
// - Frames with transmission errors get no response.
// - ACK 0x00 on success; ACK 0x1B for one byte under write-lock.
// - ACK 0xB0 after a write under program-only mode.
// - ACK 0x0C when the write waits for a checksum.
// - NACK 0x99 zone unset or bad fuses; 0xB9 write-lock denial.
// - NACK 0xA2 bad address, 0xA3 bad length, 0xA9 security needed.
// - Checksum write refused unless authentication or encryption active.
// - Checksum mismatch aborts, resets crypto engine, NACK 0xC9.
// - Checksum write is read back; NACK 0xED on mismatch.
// - Checksum-variant data encrypted in encryption mode, clear in auth.
// - Small-memory parameter 0x00 normal, 0x80 checksum; others NACK 0xA1.
// - Checksum variant length within 16-byte page, eight with anti-tearing.
`timescale 1ns/100ps
module user_zone_write_handler (
   input  wire logic              CLK_SYS,
   input  wire logic              NRST,
   input  wire wr_pkg::cfg_s      CFG,
   input  wire wr_pkg::rx_s       RX,
   input  wire logic              TX_READY,
   output logic                   TX_VALID,
   output logic [7:0]             TX_DATA,
   output logic                   TX_LAST,
   output logic                   DATA_DECRYPT,
   output logic                   CRYPTO_RST,
   output logic                   EE_REQ,
   output logic                   EE_WR,
   output logic [8:0]             EE_ADDR,
   output logic [7:0]             EE_WDATA,
   input  wire logic              EE_ACK,
   input  wire logic [7:0]        EE_RDATA
);
   typedef enum logic [2:0] {S_IDLE, S_RECV, S_PREP, S_WR, S_RD,
                             S_RESP} state_e;

   state_e       st_q,       st_d;
   wr_pkg::cfg_s cfg_q,      cfg_d;
   logic [8:0]   cnt_q,      cnt_d;
   logic [7:0]   cid_q,      cid_d;
   logic [7:0]   parameter_byte_q,    parameter_byte_d;
   logic [7:0]   alo_q,      alo_d;
   logic [7:0]   len_q,      len_d;
   logic [7:0]   status_q,   status_d;
   logic         nack_q,     nack_d;
   logic         mism_q,     mism_d;
   logic [4:0]   idx_q,      idx_d;
   logic         tx_valid_q, tx_valid_d;
   logic [7:0]   tx_data_q,  tx_data_d;
   logic         tx_last_q,  tx_last_d;
   logic [1:0]   tx_idx_q,   tx_idx_d;
   logic         ee_req_q,   ee_req_d;
   logic         ee_wr_q,    ee_wr_d;
   logic [7:0]   ee_wdata_q, ee_wdata_d;
   logic         crypto_q,   crypto_d;
   logic         decrypt_q,  decrypt_d;
   logic         chk;
   logic         start_resp;
   logic         ld;
   logic         inc;
   logic         buf_we;
   logic [8:0]   exp_cnt;
   logic [8:0]   data_end;
   logic [8:0]   data_ofs;
   logic [7:0]   buf_rdata;
   logic [8:0]   addr_q;

   // Pre-write checks in response priority order
   function automatic logic [7:0] check_status(input wr_pkg::cfg_s c,
      input logic [7:0] prm, input logic [7:0] len, input logic mac_ok);
      logic       is_chk;
      logic [7:0] lmax;
      is_chk = !c.large_mem && prm == wr_pkg::PARAMETER_BYTE_CHK;
      lmax = c.large_mem ? wr_pkg::LEN_BIG : wr_pkg::LEN_SMALL;
      if (c.anti_tear) begin
         lmax = wr_pkg::LEN_AT;
      end
      if (c.large_mem && (c.write_lock || c.prog_only)) begin
         lmax = wr_pkg::LEN_ONE;
      end
      if (!c.large_mem && !is_chk && prm != wr_pkg::PARAMETER_BYTE_NORMAL) begin
         return wr_pkg::STS_PARAMETER_BYTE;
      end else if (!c.zone_set || !c.fuses_ok) begin
         return wr_pkg::STS_DENY;
      end else if (is_chk && c.sec == wr_pkg::SEC_NORMAL) begin
         return wr_pkg::STS_SEC;
      end else if (c.large_mem && (prm & wr_pkg::ADDR_H_MASK) != 8'h00) begin
         return wr_pkg::STS_ADDR;
      end else if (len > lmax) begin
         return wr_pkg::STS_LEN;
      end else if (c.write_lock && c.lock_deny) begin
         return wr_pkg::STS_LOCK;
      end else if (is_chk && !mac_ok) begin
         return wr_pkg::STS_CHK;
      end else if (!is_chk && c.mac_pend) begin
         return wr_pkg::STS_PEND;
      end
      return wr_pkg::STS_OK;
   endfunction

   // Frame geometry; checksum bytes trail the data only in that variant
   always_comb begin
      chk      = !cfg_q.large_mem && parameter_byte_q == wr_pkg::PARAMETER_BYTE_CHK;
      data_end = wr_pkg::HDR_BYTES + {1'b0, len_q} + 9'h001;
      exp_cnt  = chk ? data_end + wr_pkg::MAC_BYTES : data_end;
      data_ofs = cnt_q - wr_pkg::HDR_BYTES;
      buf_we   = st_q == S_RECV && RX.valid && cnt_q >= wr_pkg::HDR_BYTES &&
                 cnt_q < data_end && data_ofs < 9'(wr_pkg::BUF_DEPTH);
   end

   // Address restarts at the command address for write and for read-back
   always_comb begin
      ld  = st_q == S_PREP || (st_q == S_WR && st_d == S_RD);
      inc = (st_q == S_WR && st_d == S_WR && idx_d != idx_q) ||
            (st_q == S_RD && st_d == S_RD && idx_d != idx_q);
   end

   page_buf u_buf (
      .clk   (CLK_SYS),
      .we    (buf_we),
      .waddr (data_ofs[4:0]),
      .wdata (RX.data),
      .raddr (idx_d),
      .rdata (buf_rdata)
   );

   page_addr u_addr (
      .clk      (CLK_SYS),
      .rst_n    (NRST),
      .load     (ld),
      .inc      (inc),
      .big      (cfg_q.large_mem),
      .load_val ({parameter_byte_q[0] & cfg_q.large_mem, alo_q}),
      .addr_q   (addr_q)
   );

   // Command sequencer: receive, check, write, verify, answer
   always_comb begin
      st_d       = st_q;
      cfg_d      = cfg_q;
      cnt_d      = cnt_q;
      cid_d      = cid_q;
      parameter_byte_d    = parameter_byte_q;
      alo_d      = alo_q;
      len_d      = len_q;
      status_d   = status_q;
      nack_d     = nack_q;
      mism_d     = mism_q;
      idx_d      = idx_q;
      ee_req_d   = ee_req_q;
      ee_wr_d    = ee_wr_q;
      ee_wdata_d = ee_wdata_q;
      crypto_d   = 1'b0;
      start_resp = 1'b0;
      unique case (st_q)
         S_IDLE: begin
            // Inactive cards ignore the frame entirely
            if (RX.valid && RX.first && !RX.last &&
                CFG.active) begin
               st_d   = S_RECV;
               cfg_d  = CFG;
               cid_d  = RX.data;
               cnt_d  = 9'h001;
               mism_d = 1'b0;
            end
         end
         S_RECV: begin
            if (RX.valid) begin
               cnt_d = cnt_q + 9'h001;
               if (cnt_q == wr_pkg::POS_PARAMETER_BYTE) parameter_byte_d = RX.data;
               if (cnt_q == wr_pkg::POS_ADDR)  alo_d   = RX.data;
               if (cnt_q == wr_pkg::POS_LEN)   len_d   = RX.data;
               if (RX.last) begin
                  // Bad CRC or wrong byte count: drop silently
                  if (!RX.crc_ok || cnt_d <= wr_pkg::HDR_BYTES ||
                      cnt_d != exp_cnt) begin
                     st_d = S_IDLE;
                  end else begin
                     status_d = check_status(cfg_q, parameter_byte_q, len_q,
                                             RX.mac_ok);
                     nack_d = status_d != wr_pkg::STS_OK &&
                              status_d != wr_pkg::STS_PEND;
                     crypto_d = status_d == wr_pkg::STS_CHK;
                     if (status_d == wr_pkg::STS_OK) begin
                        st_d  = S_PREP;
                        idx_d = '0;
                     end else begin
                        start_resp = 1'b1;
                     end
                  end
               end
            end
         end
         S_PREP: begin
            // One cycle lets the last staged byte reach the read port
            st_d = S_WR;
         end
         S_WR: begin
            if (!ee_req_q) begin
               ee_req_d   = 1'b1;
               ee_wr_d    = 1'b1;
               ee_wdata_d = buf_rdata;
            end else if (EE_ACK) begin
               ee_req_d = 1'b0;
               if (idx_q == len_q[4:0]) begin
                  idx_d = '0;
                  // Large-memory parts have no read-back stage
                  if (cfg_q.large_mem) begin
                     start_resp = 1'b1;
                  end else begin
                     st_d = S_RD;
                  end
               end else begin
                  idx_d = idx_q + 5'h01;
               end
            end
         end
         S_RD: begin
            if (!ee_req_q) begin
               ee_req_d = 1'b1;
               ee_wr_d  = 1'b0;
            end else if (EE_ACK) begin
               ee_req_d = 1'b0;
               if (EE_RDATA != buf_rdata) begin
                  mism_d = 1'b1;
               end
               if (idx_q == len_q[4:0]) begin
                  start_resp = 1'b1;
               end else begin
                  idx_d = idx_q + 5'h01;
               end
            end
         end
         S_RESP: begin
            if (TX_READY && tx_last_q) begin
               st_d = S_IDLE;
            end
         end
      endcase
      // Final status of a completed write
      if (start_resp) begin
         st_d = S_RESP;
         if (st_q != S_RECV) begin
            nack_d = mism_d;
            if (mism_d) begin
               status_d = wr_pkg::STS_MISM;
            end else if (cfg_q.prog_only) begin
               status_d = wr_pkg::STS_PROG;
            end else if (cfg_q.write_lock) begin
               status_d = wr_pkg::STS_ONE;
            end else begin
               status_d = wr_pkg::STS_OK;
            end
         end
      end
   end

   // Answer serialiser; CRC is appended by the framer after TX_LAST
   always_comb begin
      tx_valid_d = tx_valid_q;
      tx_data_d  = tx_data_q;
      tx_last_d  = tx_last_q;
      tx_idx_d   = tx_idx_q;
      if (start_resp) begin
         tx_valid_d = 1'b1;
         tx_data_d  = cid_q;
         tx_last_d  = 1'b0;
         tx_idx_d   = 2'h0;
      end else if (tx_valid_q && TX_READY) begin
         tx_idx_d = tx_idx_q + 2'h1;
         if (tx_last_q) begin
            tx_valid_d = 1'b0;
            tx_last_d  = 1'b0;
         end else if (tx_idx_q == 2'h0) begin
            tx_data_d = nack_q ? wr_pkg::RESP_NACK : wr_pkg::RESP_ACK;
         end else begin
            tx_data_d = status_q;
            tx_last_d = 1'b1;
         end
      end
   end

   // Flags the next received byte as an encrypted data byte
   always_comb begin
      decrypt_d = st_d == S_RECV && cfg_d.sec == wr_pkg::SEC_ENC &&
                  cnt_d >= wr_pkg::HDR_BYTES &&
                  cnt_d < wr_pkg::HDR_BYTES + {1'b0, len_d} + 9'h001;
   end

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         st_q       <= S_IDLE;
         cfg_q      <= '0;
         cnt_q      <= '0;
         cid_q      <= '0;
         parameter_byte_q    <= '0;
         alo_q      <= '0;
         len_q      <= '0;
         status_q   <= '0;
         nack_q     <= 1'b0;
         mism_q     <= 1'b0;
         idx_q      <= '0;
         tx_valid_q <= 1'b0;
         tx_data_q  <= '0;
         tx_last_q  <= 1'b0;
         tx_idx_q   <= '0;
         ee_req_q   <= 1'b0;
         ee_wr_q    <= 1'b0;
         ee_wdata_q <= '0;
         crypto_q   <= 1'b0;
         decrypt_q  <= 1'b0;
      end else begin
         st_q       <= st_d;
         cfg_q      <= cfg_d;
         cnt_q      <= cnt_d;
         cid_q      <= cid_d;
         parameter_byte_q    <= parameter_byte_d;
         alo_q      <= alo_d;
         len_q      <= len_d;
         status_q   <= status_d;
         nack_q     <= nack_d;
         mism_q     <= mism_d;
         idx_q      <= idx_d;
         tx_valid_q <= tx_valid_d;
         tx_data_q  <= tx_data_d;
         tx_last_q  <= tx_last_d;
         tx_idx_q   <= tx_idx_d;
         ee_req_q   <= ee_req_d;
         ee_wr_q    <= ee_wr_d;
         ee_wdata_q <= ee_wdata_d;
         crypto_q   <= crypto_d;
         decrypt_q  <= decrypt_d;
      end
   end

   always_comb begin
      TX_VALID     = tx_valid_q;
      TX_DATA      = tx_data_q;
      TX_LAST      = tx_last_q;
      DATA_DECRYPT = decrypt_q;
      CRYPTO_RST   = crypto_q;
      EE_REQ       = ee_req_q;
      EE_WR        = ee_wr_q;
      EE_ADDR      = addr_q;
      EE_WDATA     = ee_wdata_q;
   end

   // Checks on the sequencer
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);

   property p_silent_inactive;
      st_q == S_IDLE && RX.valid && RX.first && !CFG.active
         |=> st_q == S_IDLE [*2];
   endproperty
   a_silent_inactive: assert property (p_silent_inactive)
      else $error("inactive card left idle");

   property p_crc_drop;
      st_q == S_RECV && RX.valid && RX.last && !RX.crc_ok
         |=> st_q == S_IDLE ##1 !tx_valid_q;
   endproperty
   a_crc_drop: assert property (p_crc_drop)
      else $error("errored frame not dropped");

   property p_page_fixed;
      st_q == S_WR && $past(st_q) == S_WR
         |-> addr_q[8:5] == $past(addr_q[8:5]);
   endproperty
   a_page_fixed: assert property (p_page_fixed)
      else $error("page bits moved during write");

   property p_wrap;
      st_q == S_WR && EE_ACK && ee_req_q && cfg_q.large_mem &&
      addr_q[4:0] == 5'h1f && idx_q != len_q[4:0]
         |=> addr_q[4:0] == 5'h00;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("address did not wrap in page");

   property p_crypto_rst;
      crypto_q |-> status_q == wr_pkg::STS_CHK && nack_q && st_q == S_RESP;
   endproperty
   a_crypto_rst: assert property (p_crypto_rst)
      else $error("crypto reset without checksum failure");

   property p_chk_needs_sec;
      st_q == S_WR |-> !(chk && cfg_q.sec == wr_pkg::SEC_NORMAL);
   endproperty
   a_chk_needs_sec: assert property (p_chk_needs_sec)
      else $error("checksum write in normal mode");

   property p_one_byte;
      st_q == S_WR && cfg_q.large_mem &&
      (cfg_q.write_lock || cfg_q.prog_only) |-> len_q == wr_pkg::LEN_ONE;
   endproperty
   a_one_byte: assert property (p_one_byte)
      else $error("multi-byte write under lock");

   property p_anti_tear;
      st_q == S_WR && cfg_q.anti_tear |-> len_q <= wr_pkg::LEN_AT;
   endproperty
   a_anti_tear: assert property (p_anti_tear)
      else $error("anti-tearing length exceeded");

   property p_mismatch;
      st_q == S_RD && ee_req_q && EE_ACK && EE_RDATA != buf_rdata
         |=> ##[0:300] (tx_valid_q && tx_last_q &&
                        tx_data_q == wr_pkg::STS_MISM);
   endproperty
   a_mismatch: assert property (p_mismatch)
      else $error("read-back mismatch not reported");

   property p_resp_order;
      $rose(tx_valid_q) |-> tx_data_q == cid_q && tx_idx_q == 2'h0 &&
                            !tx_last_q;
   endproperty
   a_resp_order: assert property (p_resp_order)
      else $error("answer does not open with identifier");

   // Status must be the third byte, never an earlier one
   property p_last_third;
      tx_valid_q && tx_last_q |-> tx_idx_q == 2'h2 && tx_data_q == status_q;
   endproperty
   a_last_third: assert property (p_last_third)
      else $error("last answer byte is not the status");

   c_ok_write: cover property (tx_last_q && !nack_q &&
                               tx_data_q == wr_pkg::STS_OK);
   c_chk_fail: cover property (crypto_q);
   c_mismatch: cover property (tx_last_q && tx_data_q == wr_pkg::STS_MISM);
endmodule

// [user_zone_write_handler_test.sv]
// Self-checking bench for the user zone write handler
`timescale 1ns/100ps
module user_zone_write_handler_test;
   logic         clk_sys, nrst, crc, mok, corrupt, tx_rdy;
   logic [7:0]   fr [$];
   wr_pkg::cfg_s c, cfg;
   wr_pkg::rx_s  rx;
   wire          tx_valid, tx_last, dec, crst, ee_req, ee_wr, ee_ack;
   wire [7:0]    tx_data, ee_wdata, ee_rdata;
   wire [8:0]    ee_addr;
   int           fails = 0, compares = 0, cycles = 0, enc_n, crst_n = 0;
   logic [7:0]   sts_t [6] = '{8'h99, 8'h99, 8'h1b, 8'hb0, 8'hb9, 8'h0c};
   logic [5:0]   nk = 6'b010011;

   user_zone_write_handler uut (.CLK_SYS(clk_sys), .NRST(nrst), .CFG(cfg),
      .RX(rx), .TX_READY(tx_rdy), .TX_VALID(tx_valid), .TX_DATA(tx_data),
      .TX_LAST(tx_last), .DATA_DECRYPT(dec), .CRYPTO_RST(crst),
      .EE_REQ(ee_req), .EE_WR(ee_wr), .EE_ADDR(ee_addr),
      .EE_WDATA(ee_wdata), .EE_ACK(ee_ack), .EE_RDATA(ee_rdata));
   eeprom_model ee (.clk(clk_sys), .req(ee_req), .wr(ee_wr), .addr(ee_addr),
      .wdata(ee_wdata), .corrupt(corrupt), .ack(ee_ack), .rdata(ee_rdata));

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic final_report;
      if (fails == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Every wait after reset passes here, so the hang guard and pulse count live here
   task automatic tick;
      @(posedge clk_sys);
      #1;
      cycles++;
      if (crst === 1'b1) crst_n++;
      if (cycles == 20000) begin
         fails++;
         final_report;
      end
   endtask

   function automatic wr_pkg::cfg_s good();
      wr_pkg::cfg_s g;
      g = '0;
      {g.active, g.zone_set, g.fuses_ok} = 3'b111;
      return g;
   endfunction

   // One frame in, then the answer or silence (ak of ff)
   task automatic run(input wr_pkg::cfg_s x,
                      input logic [7:0] p, a, l, ak, st);
      int n;
      n = 0;
      fr = {8'h13, p, a, l};
      for (int k = 0; k <= l; k++) fr.push_back(8'h40 + 8'(k));
      if (p == 8'h80 && !x.large_mem) fr = {fr, 8'h5a, 8'h5b};
      cfg = x;
      enc_n = 0;
      foreach (fr[i]) begin
         if (dec === 1'b1) enc_n++;
         rx = '{1'b1, i == 0, i == fr.size() - 1, crc, mok, fr[i]};
         tick;
      end
      rx = '0;
      if (ak == 8'hff) begin
         repeat (60) begin
            n += (tx_valid !== 1'b0);
            tick;
         end
         chk(8'(n), 8'h00);
      end else begin
         for (int k = 0; k < 3; k++) begin
            while (tx_valid !== 1'b1 && n < 600) begin
               n++;
               tick;
            end
            chk(tx_data, k == 0 ? fr[0] : k == 1 ? ak : st);
            chk({7'h00, tx_last}, {7'h00, k == 2});
            // Stall the framer once; the byte must stand until taken
            if (k == 1) begin
               tx_rdy = 1'b0;
               tick;
               chk(tx_data, ak);
               tx_rdy = 1'b1;
            end
            tick;
         end
         chk({7'h00, tx_valid}, 8'h00);
         tick;
      end
   endtask

   initial begin
      {nrst, crc, mok, corrupt, tx_rdy} = 5'b01101;
      cfg = '0;
      rx = '0;
      repeat (8) @(posedge clk_sys);
      #1 nrst = 1'b1;
      tick;
      // Write from the last slot of a 16-byte page wraps to its start
      c = good();
      run(c, 8'h00, 8'h2f, 8'h02, 8'h00, 8'h00);
      chk(ee.mem[9'h020], 8'h41);
      chk(ee.mem[9'h021], 8'h42);
      c.large_mem = 1'b1;
      c.sec = wr_pkg::SEC_ENC;
      run(c, 8'h01, 8'h1f, 8'h01, 8'h00, 8'h00);
      chk(8'(enc_n), 8'h02);
      chk(ee.mem[9'h11f], 8'h40);
      chk(ee.mem[9'h100], 8'h41);
      run(c, 8'h03, 8'h00, 8'h00, 8'h01, 8'ha2);
      run(c, 8'h00, 8'h00, 8'h20, 8'h01, 8'ha3);
      c.write_lock = 1'b1;
      run(c, 8'h00, 8'h00, 8'h01, 8'h01, 8'ha3);
      run(c, 8'h00, 8'h07, 8'h00, 8'h00, 8'h1b);
      chk(ee.mem[9'h007], 8'h40);
      // Access flags, each on a single-byte write
      for (int k = 0; k < 6; k++) begin
         c = good();
         case (k)
            0: c.zone_set = 1'b0;
            1: c.fuses_ok = 1'b0;
            2: c.write_lock = 1'b1;
            3: c.prog_only = 1'b1;
            4: {c.write_lock, c.lock_deny} = 2'b11;
            default: c.mac_pend = 1'b1;
         endcase
         run(c, 8'h00, 8'h05, 8'h00, {7'h00, nk[k]}, sts_t[k]);
      end
      c = good();
      c.anti_tear = 1'b1;
      run(c, 8'h00, 8'h00, 8'h08, 8'h01, 8'ha3);
      run(c, 8'h00, 8'h08, 8'h07, 8'h00, 8'h00);
      chk(ee.mem[9'h00f], 8'h47);
      // Checksum variant across security modes and faults
      c = good();
      run(c, 8'h80, 8'h04, 8'h00, 8'h01, 8'ha9);
      c.sec = wr_pkg::SEC_AUTH;
      mok = 1'b0;
      run(c, 8'h80, 8'h04, 8'h00, 8'h01, 8'hc9);
      chk(8'(crst_n), 8'h01);
      {mok, corrupt} = 2'b11;
      run(c, 8'h80, 8'h04, 8'h00, 8'h01, 8'hed);
      corrupt = 1'b0;
      c.sec = wr_pkg::SEC_ENC;
      run(c, 8'h80, 8'h0e, 8'h02, 8'h00, 8'h00);
      chk(8'(enc_n), 8'h03);
      chk(ee.mem[9'h000], 8'h42);
      run(c, 8'h55, 8'h00, 8'h00, 8'h01, 8'ha1);
      crc = 1'b0;
      run(c, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00);
      crc = 1'b1;
      c.active = 1'b0;
      run(c, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00);
      final_report;
   end
endmodule

// [wr_pkg.sv]
// Shared constants and types for the user zone write handler
package wr_pkg;
   localparam int unsigned ADDR_W    = 9;
   localparam int unsigned BUF_AW    = 5;
   localparam int unsigned BUF_DEPTH = 32;
   localparam int unsigned OFS_BIG   = 5;
   localparam int unsigned OFS_SMALL = 4;
   // Frame layout, byte positions counted from the identifier byte
   localparam logic [8:0] POS_PARAMETER_BYTE = 9'h001;
   localparam logic [8:0] POS_ADDR  = 9'h002;
   localparam logic [8:0] POS_LEN   = 9'h003;
   localparam logic [8:0] HDR_BYTES = 9'h004;
   localparam logic [8:0] MAC_BYTES = 9'h002;
   // Length field limits (count minus one)
   localparam logic [7:0] LEN_BIG   = 8'h1f;
   localparam logic [7:0] LEN_SMALL = 8'h0f;
   localparam logic [7:0] LEN_AT    = 8'h07;
   localparam logic [7:0] LEN_ONE   = 8'h00;
   localparam logic [7:0] ADDR_H_MASK = 8'hfe;
   // Parameter byte codes
   localparam logic [7:0] PARAMETER_BYTE_NORMAL = 8'h00;
   localparam logic [7:0] PARAMETER_BYTE_CHK    = 8'h80;
   // Status codes
   localparam logic [7:0] STS_OK    = 8'h00;
   localparam logic [7:0] STS_PEND  = 8'h0c;
   localparam logic [7:0] STS_ONE   = 8'h1b;
   localparam logic [7:0] STS_DENY  = 8'h99;
   localparam logic [7:0] STS_PARAMETER_BYTE = 8'ha1;
   localparam logic [7:0] STS_ADDR  = 8'ha2;
   localparam logic [7:0] STS_LEN   = 8'ha3;
   localparam logic [7:0] STS_SEC   = 8'ha9;
   localparam logic [7:0] STS_PROG  = 8'hb0;
   localparam logic [7:0] STS_LOCK  = 8'hb9;
   localparam logic [7:0] STS_CHK   = 8'hc9;
   localparam logic [7:0] STS_MISM  = 8'hed;
   // Acknowledge indication bytes
   localparam logic [7:0] RESP_ACK  = 8'h00;
   localparam logic [7:0] RESP_NACK = 8'h01;
   localparam logic [1:0] TX_ST_IDX = 2'h1;

   typedef enum logic [1:0] {SEC_NORMAL, SEC_AUTH, SEC_ENC} sec_e;

   typedef struct packed {
      logic active;
      logic large_mem;
      logic zone_set;
      logic fuses_ok;
      logic anti_tear;
      logic write_lock;
      logic prog_only;
      logic lock_deny;
      logic mac_pend;
      sec_e sec;
   } cfg_s;

   typedef struct packed {
      logic       valid;
      logic       first;
      logic       last;
      logic       crc_ok;
      logic       mac_ok;
      logic [7:0] data;
   } rx_s;
endpackage
